//--- hw/cbc_params.svh
`ifndef CBC_PARAMS_SVH
`define CBC_PARAMS_SVH

// ****************************************
// Clock and timing
// ****************************************
`define CBC_CLK_KHZ        250000
`define CBC_FRAME_MS       250
`define CBC_MEAS_MS        50
`define CBC_BAL_MS         200
`define CBC_DWELL_MS       450000
`define CBC_HOUR_MS        3600000
`define CBC_OV_MAX_MS      2250
`define CBC_UV_MAX_MS      32000
`define CBC_FAULT_MIN_MS   16'h01F4

// ****************************************
// Start threshold mapping
// ****************************************
`define CBC_START_TOP_MV   16'h0F3C
`define CBC_START_STEP_MV  16'h0064

// ****************************************
// Register offsets
// ****************************************
`define CBC_OFS_CFG        8'h00
`define CBC_OFS_FDLY       8'h04
`define CBC_OFS_STAT       8'h08
`define CBC_OFS_CELL0      8'h10

// ****************************************
// Field positions and reset values
// ****************************************
`define CBC_CFG_MODE_LSB   0
`define CBC_CFG_TSEL_LSB   2
`define CBC_CFG_TEN_BIT    4
`define CBC_CFG_CODE_LSB   8
`define CBC_FDLY_UV_LSB    16
`define CBC_STAT_EXP_BIT   16
`define CBC_STAT_RUN_BIT   17
`define CBC_STAT_MEAS_BIT  18
`define CBC_STAT_SUSP_BIT  19
`define CBC_STAT_CHG_BIT   20
`define CBC_CFG_MODE_RST   2'h1
`define CBC_FDLY_RST       16'h01F4

`endif

//--- hw/cbc_pkg.sv
package cbc_pkg;

  // Enable field encoding
  typedef enum logic [1:0] {
    CBC_MODE_OFF    = 2'h0,
    CBC_MODE_ALWAYS = 2'h1,
    CBC_MODE_CHARGE = 2'h2,
    CBC_MODE_CHG2   = 2'h3
  } cbc_mode_t;

  typedef struct packed {
    logic [3:0] startCode;
    logic       timeoutEn;
    logic [1:0] timeoutSel;
    cbc_mode_t  mode;
  } cbc_cfg_t;

  typedef struct packed {
    logic [15:0] uvMs;
    logic [15:0] ovMs;
  } cbc_fdly_t;

  typedef enum logic [1:0] {
    CBC_BAL_IDLE,
    CBC_BAL_RUN,
    CBC_BAL_EXPIRED
  } cbc_bal_state_t;

endpackage

//--- hw/cbc_balance_ctrl.sv
`timescale 1ns/1ps
`include "cbc_params.svh"

module cbc_balance_ctrl
  import cbc_pkg::*;
#(
  parameter int NUM_CELLS    = 10,
  parameter int CODE_W       = 16,
  parameter int FRAME_CYCLES = `CBC_FRAME_MS * `CBC_CLK_KHZ,
  parameter int MEAS_CYCLES  = `CBC_MEAS_MS * `CBC_CLK_KHZ,
  parameter int DWELL_FRAMES = (`CBC_DWELL_MS + `CBC_FRAME_MS - 1) / `CBC_FRAME_MS,
  parameter int HOUR_FRAMES  = `CBC_HOUR_MS / `CBC_FRAME_MS,
  parameter int OV_MAX_FR    = `CBC_OV_MAX_MS / `CBC_FRAME_MS,
  parameter int UV_MAX_FR    = `CBC_UV_MAX_MS / `CBC_FRAME_MS
) (
  // Clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  // AHB-Lite slave
  input  wire logic                        hsel,
  input  wire logic [31:0]                 haddr,
  input  wire logic [1:0]                  htrans,
  input  wire logic                        hwrite,
  input  wire logic [2:0]                  hsize,
  input  wire logic [31:0]                 hwdata,
  input  wire logic                        hready,
  output logic                             hreadyout,
  output logic                             hresp,
  output logic [31:0]                      hrdata,
  // Cell measurement
  output logic                             measActive,
  input  wire logic                        measValid,
  input  wire logic [NUM_CELLS*CODE_W-1:0] cellCodes,
  // Charger and protection
  input  wire logic                        chargerPresentPin,
  input  wire logic                        ovTiming,
  input  wire logic                        uvTiming,
  output logic [15:0]                      ovQualMs,
  output logic [15:0]                      uvQualMs,
  // Bleed drivers
  output logic [NUM_CELLS-1:0]             bleed
);

  localparam int CW = $clog2(FRAME_CYCLES + 1);
  localparam int IW = (NUM_CELLS > 1) ? $clog2(NUM_CELLS) : 1;

  function automatic logic [15:0] startMv(input logic [3:0] code);
    startMv = `CBC_START_TOP_MV - 16'(`CBC_START_STEP_MV * {12'h000, code});
  endfunction

  function automatic logic [15:0] clampMin(input logic [15:0] v);
    clampMin = (v < `CBC_FAULT_MIN_MS) ? `CBC_FAULT_MIN_MS : v;
  endfunction

  // ****************************************
  // Charger input synchroniser
  // ****************************************
  logic chgMeta_q;
  logic chg_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      chgMeta_q <= 1'b0;
      chg_q     <= 1'b0;
    end else begin
      chgMeta_q <= chargerPresentPin;
      chg_q     <= chgMeta_q;
    end
  end

  // ****************************************
  // Measurement / balance frame
  // ****************************************
  logic [CW-1:0] frameCnt_q, frameCnt_d;
  logic          frameTick;
  logic          measSlot;

  always_comb begin
    frameTick  = (frameCnt_q == CW'(FRAME_CYCLES - 1));
    frameCnt_d = frameTick ? '0 : frameCnt_q + CW'(1);
  end

  assign measSlot = (frameCnt_q < CW'(MEAS_CYCLES));

  always_ff @(posedge core_clk) begin
    if (rst) frameCnt_q <= '0;
    else     frameCnt_q <= frameCnt_d;
  end

  // ****************************************
  // Register bus
  // ****************************************
  cbc_cfg_t    cfg_q, cfg_d;
  cbc_fdly_t   fdly_q, fdly_d;
  logic        wrPend_q, wrPend_d;
  logic [7:0]  wrAddr_q, wrAddr_d;
  logic [31:0] rdData_q, rdData_d;
  logic        cfgWrite;
  logic        addrPhase;
  logic [31:0] statWord;
  logic [CODE_W-1:0]    cells_q [NUM_CELLS];
  logic [NUM_CELLS-1:0] bleed_q;
  cbc_bal_state_t       balState_q;
  logic                 suspend;

  assign addrPhase = hsel && hready && htrans[1];
  assign cfgWrite  = wrPend_q && (wrAddr_q == `CBC_OFS_CFG);

  always_comb begin
    statWord = '0;
    statWord[NUM_CELLS-1:0]        = bleed_q;
    statWord[`CBC_STAT_EXP_BIT]    = (balState_q == CBC_BAL_EXPIRED);
    statWord[`CBC_STAT_RUN_BIT]    = (balState_q == CBC_BAL_RUN);
    statWord[`CBC_STAT_MEAS_BIT]   = measSlot;
    statWord[`CBC_STAT_SUSP_BIT]   = suspend;
    statWord[`CBC_STAT_CHG_BIT]    = chg_q;
  end

  always_comb begin
    cfg_d    = cfg_q;
    fdly_d   = fdly_q;
    wrPend_d = addrPhase && hwrite;
    wrAddr_d = addrPhase ? haddr[7:0] : wrAddr_q;
    rdData_d = rdData_q;
    if (wrPend_q) begin
      unique case (wrAddr_q)
        `CBC_OFS_CFG: begin
          cfg_d.mode       = cbc_mode_t'(hwdata[`CBC_CFG_MODE_LSB +: 2]);
          cfg_d.timeoutSel = hwdata[`CBC_CFG_TSEL_LSB +: 2];
          cfg_d.timeoutEn  = hwdata[`CBC_CFG_TEN_BIT];
          cfg_d.startCode  = hwdata[`CBC_CFG_CODE_LSB +: 4];
        end
        `CBC_OFS_FDLY: begin
          fdly_d = hwdata;
        end
        default: begin
        end
      endcase
    end
    if (addrPhase && !hwrite) begin
      rdData_d = '0;
      if (haddr[7:0] == `CBC_OFS_CFG) begin
        rdData_d[`CBC_CFG_MODE_LSB +: 2] = cfg_d.mode;
        rdData_d[`CBC_CFG_TSEL_LSB +: 2] = cfg_d.timeoutSel;
        rdData_d[`CBC_CFG_TEN_BIT]       = cfg_d.timeoutEn;
        rdData_d[`CBC_CFG_CODE_LSB +: 4] = cfg_d.startCode;
      end else if (haddr[7:0] == `CBC_OFS_FDLY) begin
        rdData_d = fdly_d;
      end else if (haddr[7:0] == `CBC_OFS_STAT) begin
        rdData_d = statWord;
      end else begin
        for (int i = 0; i < NUM_CELLS; i++) begin
          if (haddr[7:0] == `CBC_OFS_CELL0 + 8'(4 * i)) begin
            rdData_d[CODE_W-1:0] = cells_q[i];
          end
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cfg_q.mode       <= cbc_mode_t'(`CBC_CFG_MODE_RST);
      cfg_q.timeoutSel <= 2'h0;
      cfg_q.timeoutEn  <= 1'b0;
      cfg_q.startCode  <= 4'h0;
      fdly_q.ovMs      <= `CBC_FDLY_RST;
      fdly_q.uvMs      <= `CBC_FDLY_RST;
      wrPend_q         <= 1'b0;
      wrAddr_q         <= 8'h00;
      rdData_q         <= 32'h0000_0000;
    end else begin
      cfg_q    <= cfg_d;
      fdly_q   <= fdly_d;
      wrPend_q <= wrPend_d;
      wrAddr_q <= wrAddr_d;
      rdData_q <= rdData_d;
    end
  end

  // Zero-wait slave, never errors
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdData_q;

  assign ovQualMs = clampMin(fdly_q.ovMs);
  assign uvQualMs = clampMin(fdly_q.uvMs);

  // ****************************************
  // Cell capture
  // ****************************************
  logic [CODE_W-1:0] cells_d [NUM_CELLS];

  always_comb begin
    for (int i = 0; i < NUM_CELLS; i++) begin
      cells_d[i] = cells_q[i];
      if (measValid && (bleed_q == '0)) begin
        cells_d[i] = cellCodes[i*CODE_W +: CODE_W];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    for (int i = 0; i < NUM_CELLS; i++) begin
      if (rst) cells_q[i] <= '0;
      else     cells_q[i] <= cells_d[i];
    end
  end

  // ****************************************
  // Fault timing suspension
  // ****************************************
  logic [7:0] ovFr_q, ovFr_d;
  logic [7:0] uvFr_q, uvFr_d;

  always_comb begin
    ovFr_d = ovTiming ? ovFr_q : 8'h00;
    uvFr_d = uvTiming ? uvFr_q : 8'h00;
    if (ovTiming && frameTick && (ovFr_q < 8'(OV_MAX_FR))) ovFr_d = ovFr_q + 8'h01;
    if (uvTiming && frameTick && (uvFr_q < 8'(UV_MAX_FR))) uvFr_d = uvFr_q + 8'h01;
  end

  assign suspend = (ovTiming && (ovFr_q < 8'(OV_MAX_FR)))
                || (uvTiming && (uvFr_q < 8'(UV_MAX_FR)));

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ovFr_q <= 8'h00;
      uvFr_q <= 8'h00;
    end else begin
      ovFr_q <= ovFr_d;
      uvFr_q <= uvFr_d;
    end
  end

  // ****************************************
  // Balance decision and timer
  // ****************************************
  logic [31:0]          dwellCnt_q, dwellCnt_d;
  logic [23:0]          timer_q, timer_d;
  logic [NUM_CELLS-1:0] pick_q, pick_d;
  logic [NUM_CELLS-1:0] bleed_d;
  cbc_bal_state_t       balState_d;
  logic [CODE_W-1:0]    maxV;
  logic [IW-1:0]        maxIdx;
  logic                 above;
  logic                 dwellTick;
  logic                 allow;
  logic                 chgOnly;

  always_comb begin
    maxV   = cells_q[0];
    maxIdx = '0;
    for (int i = 1; i < NUM_CELLS; i++) begin
      if (cells_q[i] > maxV) begin
        maxV   = cells_q[i];
        maxIdx = IW'(i);
      end
    end
  end

  assign above     = (32'(maxV) > 32'(startMv(cfg_q.startCode)));
  assign dwellTick = frameTick && (dwellCnt_q == 32'h0000_0000);
  assign chgOnly   = cfg_q.mode[1];

  always_comb begin
    balState_d = balState_q;
    timer_d    = timer_q;
    pick_d     = pick_q;
    dwellCnt_d = dwellCnt_q;
    if (frameTick) begin
      dwellCnt_d = dwellTick ? 32'(DWELL_FRAMES - 1) : dwellCnt_q - 32'h0000_0001;
    end
    unique case (balState_q)
      CBC_BAL_IDLE: begin
        if (dwellTick && above && (cfg_q.mode != CBC_MODE_OFF)) begin
          balState_d = CBC_BAL_RUN;
          timer_d    = '0;
        end
      end
      CBC_BAL_RUN: begin
        if (frameTick) timer_d = timer_q + 24'h00_0001;
        if (cfg_q.timeoutEn && (timer_q >= (24'(HOUR_FRAMES) << cfg_q.timeoutSel))) begin
          balState_d = CBC_BAL_EXPIRED;
        end
      end
      CBC_BAL_EXPIRED: begin
      end
    endcase
    if (dwellTick) begin
      pick_d = '0;
      if (above && (cfg_q.mode != CBC_MODE_OFF)) pick_d[maxIdx] = 1'b1;
    end
    if (balState_q == CBC_BAL_EXPIRED) pick_d = '0;
    // Reprogramming restarts the balance timer
    if (cfgWrite) begin
      balState_d = CBC_BAL_IDLE;
      timer_d    = '0;
    end
  end

  always_comb begin
    allow = 1'b1;
    if (cfg_q.mode == CBC_MODE_OFF) allow = 1'b0;
    if (balState_q == CBC_BAL_EXPIRED) allow = 1'b0;
    if (chgOnly && !chg_q) allow = 1'b0;
    // Off during measurement
    // Looks one cycle ahead: the registered output must already be low
    if (frameCnt_d < CW'(MEAS_CYCLES)) allow = 1'b0;
    if (suspend) allow = 1'b0;
    bleed_d = allow ? pick_q : '0;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      balState_q <= CBC_BAL_IDLE;
      timer_q    <= 24'h00_0000;
      pick_q     <= '0;
      dwellCnt_q <= 32'h0000_0000;
      bleed_q    <= '0;
    end else begin
      balState_q <= balState_d;
      timer_q    <= timer_d;
      pick_q     <= pick_d;
      dwellCnt_q <= dwellCnt_d;
      bleed_q    <= bleed_d;
    end
  end

  assign bleed      = bleed_q;
  assign measActive = measSlot;

endmodule // cbc_balance_ctrl

//--- bench/cbc_balance_monitor.sv
`timescale 1ns/1ps
module cbc_balance_monitor
  import cbc_pkg::*;
#(
  parameter int NUM_CELLS    = 10,
  parameter int FRAME_CYCLES = 100,
  parameter int MEAS_CYCLES  = 20
) (
  // Clock and reset
  input wire logic                 core_clk,
  input wire logic                 rst,
  // Watched signals
  input wire logic                 measActive,
  input wire logic                 ovTiming,
  input wire logic                 uvTiming,
  input wire logic [15:0]          ovQualMs,
  input wire logic [15:0]          uvQualMs,
  input wire logic [NUM_CELLS-1:0] bleed
);
  // ****
  // Slot run length
  // ****
  logic measPrev_q;
  int   run_q;
  int   run_d;
  // Counts reset cycles out so the first frame measures true
  always_comb run_d = (measActive == measPrev_q) ? run_q + 1 : 1;
  always_ff @(posedge core_clk) begin
    measPrev_q <= measActive;
    run_q      <= rst ? 0 : run_d;
  end
  // ****
  // Properties
  // ****
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  sequence s_quiet;
    (bleed == '0) [*8];
  endsequence
  a_bleed_onehot: assert property ($onehot0(bleed))
    else $error("more than one bleed output");
  a_meas_quiet: assert property (measActive |-> bleed == '0)
    else $error("bleed during measurement");
  a_fault_floor: assert property (ovQualMs >= 16'h01F4 && uvQualMs >= 16'h01F4)
    else $error("fault delay below floor");
  a_meas_length: assert property ($fell(measActive) |-> run_q == MEAS_CYCLES)
    else $error("measure slot length wrong");
  a_gap_length: assert property ($rose(measActive) |-> run_q == FRAME_CYCLES - MEAS_CYCLES)
    else $error("balance slot length wrong");
  a_ov_pause: assert property ($rose(ovTiming) |=> s_quiet)
    else $error("bleed during overvoltage timing");
  a_uv_pause: assert property ($rose(uvTiming) |=> s_quiet)
    else $error("bleed during undervoltage timing");
  a_pick_hold: assert property (bleed != '0 && $past(bleed) != '0 |-> bleed == $past(bleed))
    else $error("pick changed between updates");
endmodule // cbc_balance_monitor

bind cbc_balance_ctrl cbc_balance_monitor #(
  .NUM_CELLS(NUM_CELLS), .FRAME_CYCLES(FRAME_CYCLES), .MEAS_CYCLES(MEAS_CYCLES)
) cbc_balance_monitor_i (
  .core_clk(core_clk), .rst(rst), .measActive(measActive), .ovTiming(ovTiming),
  .uvTiming(uvTiming), .ovQualMs(ovQualMs), .uvQualMs(uvQualMs), .bleed(bleed)
);

//--- bench/cbc_stack_model.sv
`timescale 1ns/1ps
module cbc_stack_model #(
  parameter int NUM_CELLS = 10
) (
  // Clock and slot
  input wire logic                    core_clk,
  input wire logic                    measActive,
  // Bench commands
  input wire logic                    extraPulse,
  input wire logic                    chgReq,
  input wire logic [NUM_CELLS*16-1:0] setCodes,
  // Stack side
  output logic                        measValid,
  output logic                        chargerPresentPin,
  output logic [NUM_CELLS*16-1:0]     cellCodes
);
  logic [4:0] sh_q = 5'h00;
  always @(posedge core_clk) sh_q <= {sh_q[3:0], measActive};
  // Sample four cycles after the slot opens, once the sense lines settled
  assign measValid = (sh_q[3] & ~sh_q[4]) | extraPulse;
  // Sense data is not held outside a strobe
  assign cellCodes = measValid ? setCodes : ~setCodes;
  assign chargerPresentPin = chgReq;
endmodule // cbc_stack_model

//--- bench/cbc_balance_ctrl_tb_top.sv
`timescale 1ns/1ps
module cbc_balance_ctrl_tb_top;
  import cbc_pkg::*;
  localparam int NC = 10;
  localparam int FR = 100;
  localparam logic [NC*16-1:0] PAT = {{6{16'hDAC}}, 16'h1004, {3{16'hDAC}}};
  logic core_clk = 0, rst = 1, hsel = 0, hwrite = 0, ovTiming = 0, uvTiming = 0;
  logic chgReq = 0, extraPulse = 0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hi;
  logic [NC*16-1:0] setCodes = '0;
  logic [NC-1:0] ex;
  wire logic hreadyout, hresp, measActive, measValid, chargerPresentPin, hready;
  wire logic [31:0] hrdata;
  wire logic [15:0] ovQualMs, uvQualMs;
  wire logic [NC-1:0] bleed;
  wire logic [NC*16-1:0] cellCodes;
  int failures = 0, samplesChecked = 0, n;
  logic [3:0] code;
  assign hready = hreadyout;
  always #2 core_clk = ~core_clk;
  cbc_balance_ctrl #(.NUM_CELLS(NC), .FRAME_CYCLES(FR), .MEAS_CYCLES(20), .DWELL_FRAMES(3),
    .HOUR_FRAMES(4), .OV_MAX_FR(2), .UV_MAX_FR(4)) cbc_balance_ctrl_i (
    .core_clk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .measActive, .measValid, .cellCodes, .chargerPresentPin,
    .ovTiming, .uvTiming, .ovQualMs, .uvQualMs, .bleed);
  cbc_stack_model #(.NUM_CELLS(NC)) cbc_stack_model_i (.core_clk, .measActive, .extraPulse,
    .chgReq, .setCodes, .measValid, .chargerPresentPin, .cellCodes);
  // ****
  // Helpers
  // ****
  task stop_test;
    if (failures == 0 && samplesChecked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  // Only the watchdog bounds a wait for ready
  task waitRdy;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
  endtask
  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    waitRdy;
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy;
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask
  // Lands a few cycles into the balance slot, off the edge
  task waitBal;
    @(negedge measActive);
    cyc(3);
    #1;
  endtask
  function automatic logic [31:0] cfg(input int m, input int s, input int t, input int c);
    cfg = {20'h0, 4'(c), 3'h0, 1'(t), 2'(s), 2'(m)};
  endfunction
  function automatic logic [NC-1:0] expPick(input logic [NC*16-1:0] c, input logic [3:0] k);
    logic [15:0] best;
    int bi;
    best = 16'hF3C - 16'h64 * k;
    bi = -1;
    for (int i = 0; i < NC; i++)
      if (c[i*16+:16] > best) begin
        best = c[i*16+:16];
        bi = i;
      end
    expPick = '0;
    if (bi >= 0) expPick[bi] = 1'b1;
  endfunction
  function automatic logic [NC*16-1:0] mk(input int i);
    for (int j = 0; j < NC; j++)
      mk[j*16+:16] = (i == 0) ? 16'hFA0 : (i == 1) ? 16'hF3C : 16'h7D0 + 16'($urandom % 2200);
  endfunction
  initial begin
    #400000;
    failures++;
    $display("[ERR] %0t run did not finish", $time);
    stop_test;
  end
  // ****
  // Tests
  // ****
  initial begin
    void'($urandom(32'h7310F8C3));
    cyc(10);
    rst <= 1'b0;
    ahb(0, 32'h00, 0);
    chk(rd, 32'h1);
    ahb(0, 32'h04, 0);
    chk(rd, 32'h01F401F4);
    ahb(0, 32'h80, 0);
    chk(rd, 32'h0);
    ahb(1, 32'h04, 32'h00640064);
    #1;
    chk({uvQualMs, ovQualMs}, 32'h01F401F4);
    ahb(1, 32'h04, 32'h025807D0);
    #1;
    chk({uvQualMs, ovQualMs}, 32'h025807D0);
    for (int i = 0; i < 10; i++) begin
      code = (i < 2) ? 4'h0 : 4'($urandom % 16);
      @(posedge core_clk);
      setCodes <= mk(i);
      ahb(1, 32'h00, cfg(1, 0, 0, code));
      cyc(7 * FR);
      waitBal;
      ex = expPick(setCodes, code);
      chk(bleed, ex);
      if (ex != '0) begin
        hi = setCodes[31:0];
        @(posedge core_clk);
        setCodes   <= ~setCodes;
        extraPulse <= 1'b1;
        @(posedge core_clk);
        extraPulse <= 1'b0;
        ahb(0, 32'h14, 0);
        chk(rd, {16'h0, hi[31:16]});
      end
    end
    @(posedge core_clk);
    setCodes <= PAT;
    for (int m = 0; m < 4; m++)
      for (int c = 0; c < 2; c++) begin
        @(posedge core_clk);
        chgReq <= 1'(c);
        ahb(1, 32'h00, cfg(m, 0, 0, 0));
        cyc(7 * FR);
        waitBal;
        ex = (m == 1 || (m >= 2 && c == 1)) ? 10'h008 : 10'h000;
        chk(bleed, ex);
        if (ex != '0 && m >= 2) begin
          @(posedge core_clk);
          chgReq <= 1'b0;
          cyc(4);
          #1;
          chk(bleed, 0);
        end
      end
    // Bleed must stand for exactly 4<<s frames, then stop
    for (int s = 0; s < 4; s++) begin
      @(posedge core_clk);
      setCodes <= '0;
      cyc(7 * FR);
      @(posedge core_clk);
      setCodes <= PAT;
      ahb(1, 32'h00, cfg(1, s, 1, 0));
      for (n = 0; n < 1000 && bleed === '0; n++) @(posedge core_clk);
      chk(32'(n < 1000), 32'h1);
      cyc(((4 << s) - 2) * FR);
      waitBal;
      chk(bleed, 10'h008);
      waitBal;
      chk(bleed, 0);
      ahb(0, 32'h08, 0);
      chk(rd[16], 1'b1);
    end
    ahb(1, 32'h00, cfg(1, 0, 0, 0));
    for (int k = 0; k < 2; k++) begin
      cyc(7 * FR);
      waitBal;
      chk(bleed, 10'h008);
      @(posedge core_clk);
      if (k == 0) ovTiming <= 1'b1;
      else uvTiming <= 1'b1;
      cyc(2);
      #1;
      chk(bleed, 0);
      cyc((k == 0 ? 4 : 6) * FR);
      waitBal;
      chk(bleed, 10'h008);
      @(posedge core_clk);
      ovTiming <= 1'b0;
      uvTiming <= 1'b0;
    end
    stop_test;
  end
endmodule // cbc_balance_ctrl_tb_top
